// [src/dmr_unit.sv]
// Functional notes
// - signed multiply: opcode zero, function 011100, ten middle bits zero.
// - signed multiply treats operands as two's complement, full 128-bit product.
// - unsigned multiply: opcode zero, function 011101, operands zero-extended.
// - unsigned multiply treats both operands as unsigned magnitudes.
// - product bits 63..0 to bottom half, 127..64 to top half.
// - without release 6 multiplies never raise an exception nor flag overflow.
// - with release 6 enabled both multiplies raise reserved-instruction.
// - multiply runs multi-cycle; product reads stall until result written.
// - immediate rotate: opcode zero, bits 25..22 zero, bit 21 set, function 111010.
// - immediate rotate right by 0..31, wrapped bits re-enter at top.
// - plus-32 rotate: bit 21 set, function 111110, amount field plus 32.
// - variable rotate: bits 10..7 zero, bit 6 set, low six bits of source a.
`timescale 1ns/1ps
module dmr_unit (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire dmr_pkg::dmr_issue_t i_issue,
    input wire logic i_release6,
    input wire dmr_pkg::dmr_rd_req_t i_prod_rd,
    output dmr_pkg::dmr_rot_res_t o_rot,
    output dmr_pkg::dmr_rd_res_t o_prod_rd,
    output logic o_rsvd_instr,
    output logic o_shift_pass,
    output logic o_mul_busy
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    dmr_pkg::dmr_op_t op;
    logic is_mul;
    logic mul_issue;
    logic mul_done;
    logic [127:0] mul_product;
    logic pending_r;
    logic [63:0] prod_bottom_r;
    logic [63:0] prod_top_r;
    logic [5:0] imm_amt;
    logic [5:0] var_amt;

    assign op = i_issue.valid ? dmr_pkg::dmr_decode(i_issue.instr) : dmr_pkg::OP_NONE;
    assign is_mul = (op == dmr_pkg::OP_MUL_S) || (op == dmr_pkg::OP_MUL_U);
    assign mul_issue = is_mul && !i_release6 && !pending_r;
    assign imm_amt = {1'b0, i_issue.instr[dmr_pkg::SA_MSB:dmr_pkg::SA_LSB]};
    assign var_amt = i_issue.src_a[dmr_pkg::VAR_AMT_MSB:0];

    // ----------------------------------------------------------------
    // multiplier
    // ----------------------------------------------------------------
    dmr_mul_seq i_dmr_mul_seq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(mul_issue),
        .i_signed(op == dmr_pkg::OP_MUL_S),
        .i_a(i_issue.src_a),
        .i_b(i_issue.src_b),
        .o_done(mul_done),
        .o_product(mul_product)
    );

    // ----------------------------------------------------------------
    // product registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prod_bottom_r <= dmr_pkg::PROD_RST;
            prod_top_r <= dmr_pkg::PROD_RST;
        end else if (mul_done) begin
            prod_bottom_r <= mul_product[63:0];
            prod_top_r <= mul_product[127:64];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pending_r <= 1'b0;
        end else if (mul_issue) begin
            pending_r <= 1'b1;
        end else if (mul_done) begin
            pending_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mul_busy <= 1'b0;
        end else begin
            o_mul_busy <= mul_issue || (pending_r && !mul_done);
        end
    end

    // ----------------------------------------------------------------
    // product read port
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_prod_rd <= '0;
        end else begin
            o_prod_rd.stall <= i_prod_rd.req && (pending_r || mul_issue);
            o_prod_rd.valid <= i_prod_rd.req && !pending_r && !mul_issue;
            if (i_prod_rd.req && !pending_r && !mul_issue) begin
                o_prod_rd.data <= i_prod_rd.top ? prod_top_r : prod_bottom_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // rotates and exceptions
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rot <= '0;
        end else begin
            o_rot.valid <= 1'b0;
            case (op)
                dmr_pkg::OP_ROT_IMM: begin
                    o_rot.valid <= 1'b1;
                    o_rot.data <= dmr_pkg::dmr_rotr(i_issue.src_b, imm_amt);
                end
                dmr_pkg::OP_ROT_IMM32: begin
                    o_rot.valid <= 1'b1;
                    o_rot.data <= dmr_pkg::dmr_rotr(i_issue.src_b, {1'b1, imm_amt[4:0]});
                end
                dmr_pkg::OP_ROT_VAR: begin
                    o_rot.valid <= 1'b1;
                    o_rot.data <= dmr_pkg::dmr_rotr(i_issue.src_b, var_amt);
                end
                default: begin
                    o_rot.valid <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rsvd_instr <= 1'b0;
            o_shift_pass <= 1'b0;
        end else begin
            o_rsvd_instr <= is_mul && i_release6;
            o_shift_pass <= (op == dmr_pkg::OP_SHIFT_PASS);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic [63:0] chk_a_r;
    logic [63:0] chk_b_r;
    logic chk_signed_r;
    logic [127:0] exp_prod;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            chk_a_r <= 64'h0;
            chk_b_r <= 64'h0;
            chk_signed_r <= 1'b0;
        end else if (mul_issue) begin
            chk_a_r <= i_issue.src_a;
            chk_b_r <= i_issue.src_b;
            chk_signed_r <= (op == dmr_pkg::OP_MUL_S);
        end
    end

    assign exp_prod = chk_signed_r
        ? 128'($signed({{64{chk_a_r[63]}}, chk_a_r}) * $signed({{64{chk_b_r[63]}}, chk_b_r}))
        : 128'({64'h0, chk_a_r} * {64'h0, chk_b_r});

    chk_signed_mul_decode: assert property (
        (i_issue.valid && i_issue.instr[31:26] == 6'h00 && i_issue.instr[15:0] == 16'h001C
         && !i_release6 && !pending_r)
        |=> pending_r && chk_signed_r)
        else $error("signed multiply not started");
    chk_signed_mul_result: assert property (
        (mul_done && chk_signed_r) |=> {prod_top_r, prod_bottom_r} == exp_prod)
        else $error("signed product wrong");
    chk_unsigned_mul_decode: assert property (
        (i_issue.valid && i_issue.instr[31:26] == 6'h00 && i_issue.instr[15:0] == 16'h001D
         && !i_release6 && !pending_r)
        |=> pending_r && !chk_signed_r)
        else $error("unsigned multiply not started");
    chk_unsigned_mul_result: assert property (
        (mul_done && !chk_signed_r) |=> {prod_top_r, prod_bottom_r} == exp_prod)
        else $error("unsigned product wrong");
    chk_halves_placed: assert property (
        mul_done |=> prod_bottom_r == $past(mul_product[63:0]) && prod_top_r == $past(mul_product[127:64]))
        else $error("product halves misplaced");
    chk_no_mul_trap: assert property (
        (is_mul && !i_release6) |=> !o_rsvd_instr)
        else $error("multiply raised exception");
    chk_rel6_trap: assert property (
        (is_mul && i_release6 && !pending_r) |=> o_rsvd_instr && !pending_r)
        else $error("release 6 multiply not trapped");
    chk_mul_latency: assert property (
        mul_issue |-> ##65 mul_done)
        else $error("multiply latency wrong");
    chk_read_stalls: assert property (
        (i_prod_rd.req && pending_r) |=> o_prod_rd.stall && !o_prod_rd.valid)
        else $error("product read not stalled");
    chk_rot_imm: assert property (
        (op == dmr_pkg::OP_ROT_IMM) |=>
        o_rot.valid && o_rot.data == (($past(i_issue.src_b) >> $past(imm_amt))
        | ($past(i_issue.src_b) << (7'd64 - {1'b0, $past(imm_amt)}))))
        else $error("immediate rotate wrong");
    chk_rot_imm_decode: assert property (
        (i_issue.valid && i_issue.instr[31:21] == 11'h001 && i_issue.instr[5:0] == 6'h3A)
        |=> o_rot.valid && !o_shift_pass)
        else $error("immediate rotate not decoded");
    chk_rot_plus32: assert property (
        (op == dmr_pkg::OP_ROT_IMM32) |=>
        o_rot.valid && o_rot.data == (($past(i_issue.src_b) >> (7'h20 + {1'h0, $past(imm_amt)}))
        | ($past(i_issue.src_b) << (7'h20 - {1'h0, $past(imm_amt)}))))
        else $error("plus-32 rotate wrong");
    chk_rot_var: assert property (
        (op == dmr_pkg::OP_ROT_VAR) |=>
        o_rot.valid && o_rot.data == (($past(i_issue.src_b) >> $past(var_amt))
        | ($past(i_issue.src_b) << (7'h40 - {1'h0, $past(var_amt)}))))
        else $error("variable rotate wrong");
    chk_shift_handoff: assert property (
        (op == dmr_pkg::OP_SHIFT_PASS) |=> o_shift_pass && !o_rot.valid)
        else $error("shift encoding not handed off");
    chk_rot_field_zero: assert property (
        (i_issue.valid && i_issue.instr[31:26] == 6'h00 && i_issue.instr[25:22] != 4'h0
         && i_issue.instr[5:0] == 6'h3A) |=> !o_rot.valid && !o_shift_pass)
        else $error("rotate with nonzero field decoded");
    chk_rot_pulse: assert property (
        o_rot.valid |-> $past(i_issue.valid))
        else $error("rotate result without issue");
    chk_busy_span: assert property (
        mul_issue |=> o_mul_busy [*8])
        else $error("multiply busy dropped early");
    chk_busy_clear: assert property (
        mul_done |=> !o_mul_busy && !pending_r)
        else $error("multiply busy not cleared");
    chk_read_answered: assert property (
        (i_prod_rd.req && !pending_r && !mul_issue) |=> o_prod_rd.valid && !o_prod_rd.stall)
        else $error("product read not answered");

    cov_signed_mul: cover property (mul_done && chk_signed_r && exp_prod[127]);
    cov_stalled_read: cover property (o_prod_rd.stall ##[1:80] o_prod_rd.valid);
    cov_var_rotate: cover property (o_rot.valid && $past(op == dmr_pkg::OP_ROT_VAR));
    cov_rel6_trap: cover property (o_rsvd_instr);
    cov_unsigned_mul: cover property (mul_done && !chk_signed_r);

endmodule

// [src/dmr_pkg.sv]
package dmr_pkg;

    // ----------------------------------------------------------------
    // instruction fields
    // ----------------------------------------------------------------
    localparam int OPC_MSB = 31;
    localparam int OPC_LSB = 26;
    localparam int FN_MSB = 5;
    localparam int FN_LSB = 0;
    localparam int SA_MSB = 10;
    localparam int SA_LSB = 6;
    localparam int MUL_ZERO_MSB = 15;
    localparam int MUL_ZERO_LSB = 6;
    localparam int RIMM_ZERO_MSB = 25;
    localparam int RIMM_ZERO_LSB = 22;
    localparam int RIMM_SEL_BIT = 21;
    localparam int RVAR_ZERO_MSB = 10;
    localparam int RVAR_ZERO_LSB = 7;
    localparam int RVAR_SEL_BIT = 6;
    localparam int VAR_AMT_MSB = 5;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [5:0] FN_MUL_SIGNED = 6'h1C;
    localparam logic [5:0] FN_MUL_UNSIGNED = 6'h1D;
    localparam logic [5:0] FN_ROT_IMM = 6'h3A;
    localparam logic [5:0] FN_ROT_IMM32 = 6'h3E;
    localparam logic [5:0] FN_ROT_VAR = 6'h16;
    localparam logic [9:0] MUL_ZERO = 10'h000;
    localparam logic [3:0] ROT_ZERO = 4'h0;

    // ----------------------------------------------------------------
    // timing and reset values
    // ----------------------------------------------------------------
    localparam int MUL_STEPS = 64;
    localparam logic [6:0] MUL_LAST = 7'(MUL_STEPS - 1);
    localparam int MUL_LATENCY = MUL_STEPS + 1;
    localparam logic [63:0] PROD_RST = 64'h0000_0000_0000_0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_MUL_S, OP_MUL_U, OP_ROT_IMM, OP_ROT_IMM32, OP_ROT_VAR, OP_SHIFT_PASS
    } dmr_op_t;

    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [63:0] src_a;
        logic [63:0] src_b;
    } dmr_issue_t;

    typedef struct packed {
        logic req;
        logic top;
    } dmr_rd_req_t;

    typedef struct packed {
        logic valid;
        logic stall;
        logic [63:0] data;
    } dmr_rd_res_t;

    typedef struct packed {
        logic valid;
        logic [63:0] data;
    } dmr_rot_res_t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic dmr_op_t dmr_decode(input logic [31:0] ins);
        logic [5:0] fn;
        dmr_op_t op;
        fn = ins[FN_MSB:FN_LSB];
        op = OP_NONE;
        if (ins[OPC_MSB:OPC_LSB] == OPC_SPECIAL) begin
            if (fn == FN_MUL_SIGNED && ins[MUL_ZERO_MSB:MUL_ZERO_LSB] == MUL_ZERO) begin
                op = OP_MUL_S;
            end else if (fn == FN_MUL_UNSIGNED && ins[MUL_ZERO_MSB:MUL_ZERO_LSB] == MUL_ZERO) begin
                op = OP_MUL_U;
            end else if ((fn == FN_ROT_IMM || fn == FN_ROT_IMM32)
                         && ins[RIMM_ZERO_MSB:RIMM_ZERO_LSB] == ROT_ZERO) begin
                if (!ins[RIMM_SEL_BIT]) begin
                    op = OP_SHIFT_PASS;
                end else if (fn == FN_ROT_IMM) begin
                    op = OP_ROT_IMM;
                end else begin
                    op = OP_ROT_IMM32;
                end
            end else if (fn == FN_ROT_VAR && ins[RVAR_ZERO_MSB:RVAR_ZERO_LSB] == ROT_ZERO) begin
                op = ins[RVAR_SEL_BIT] ? OP_ROT_VAR : OP_SHIFT_PASS;
            end
        end
        return op;
    endfunction

    function automatic logic [63:0] dmr_rotr(input logic [63:0] v, input logic [5:0] s);
        logic [127:0] t;
        t = {v, v} >> s;
        return t[63:0];
    endfunction

endpackage

// [src/dmr_mul_seq.sv]
`timescale 1ns/1ps
module dmr_mul_seq (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic i_signed,
    input wire logic [63:0] i_a,
    input wire logic [63:0] i_b,
    output logic o_done,
    output logic [127:0] o_product
);

    // ----------------------------------------------------------------
    // shift-add on magnitudes, sign applied at the end
    // ----------------------------------------------------------------
    logic busy_r;
    logic [6:0] cnt_r;
    logic [127:0] acc_r;
    logic [127:0] mcand_r;
    logic [63:0] mplier_r;
    logic neg_r;
    logic [127:0] acc_nxt;
    logic [63:0] mag_a;
    logic [63:0] mag_b;

    assign mag_a = (i_signed && i_a[63]) ? 64'(-i_a) : i_a;
    assign mag_b = (i_signed && i_b[63]) ? 64'(-i_b) : i_b;
    assign acc_nxt = mplier_r[0] ? 128'(acc_r + mcand_r) : acc_r;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_r <= 1'b0;
            cnt_r <= 7'h00;
            acc_r <= 128'h0;
            mcand_r <= 128'h0;
            mplier_r <= 64'h0;
            neg_r <= 1'b0;
        end else if (i_start && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r <= 7'h00;
            acc_r <= 128'h0;
            mcand_r <= {64'h0, mag_a};
            mplier_r <= mag_b;
            neg_r <= i_signed && (i_a[63] ^ i_b[63]);
        end else if (busy_r) begin
            acc_r <= acc_nxt;
            mcand_r <= {mcand_r[126:0], 1'b0};
            mplier_r <= {1'b0, mplier_r[63:1]};
            cnt_r <= 7'(cnt_r + 7'h01);
            if (cnt_r == dmr_pkg::MUL_LAST) begin
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_done <= 1'b0;
            o_product <= 128'h0;
        end else begin
            o_done <= busy_r && (cnt_r == dmr_pkg::MUL_LAST);
            if (busy_r && (cnt_r == dmr_pkg::MUL_LAST)) begin
                o_product <= neg_r ? 128'(-acc_nxt) : acc_nxt;
            end
        end
    end

endmodule

// [dv/dmr_pipe_model.sv]
`timescale 1ns/1ps
module dmr_pipe_model (
    input wire logic i_clk,
    input wire dmr_pkg::dmr_rd_res_t i_rd_res,
    output dmr_pkg::dmr_issue_t o_issue,
    output dmr_pkg::dmr_rd_req_t o_rd_req
);
    // ----------------------------------------------------------------
    // decode and register read stages, driven on the falling edge
    // ----------------------------------------------------------------
    initial begin
        o_issue = '0;
        o_rd_req = '0;
    end

    // presents one instruction, called at a falling edge; it stays valid until the next issue or idle
    task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
        o_issue = '{valid: 1'h1, instr: ins, src_a: a, src_b: b};
        @(negedge i_clk);
    endtask

    // released fields show the inverse of their last value
    task automatic idle();
        o_issue = '{valid: 1'h0, instr: ~o_issue.instr, src_a: ~o_issue.src_a, src_b: ~o_issue.src_b};
    endtask

    // holds the read until valid, counting cycles held off
    task automatic read(input logic top, output logic [63:0] data, output int stalls);
        int n;
        n = 0;
        stalls = 0;
        data = '0;
        o_rd_req = '{req: 1'h1, top: top};
        while (n < 300) begin
            @(negedge i_clk);
            n++;
            if (i_rd_res.stall === 1'h1) begin
                stalls++;
            end
            if (i_rd_res.valid === 1'h1) begin
                data = i_rd_res.data;
                n = 1000;
            end
        end
        o_rd_req = '{req: 1'h0, top: ~top};
        @(negedge i_clk);
    endtask
endmodule

// [dv/test_dmr_unit.sv]
`timescale 1ns/1ps
module test_dmr_unit;
    logic i_clk;
    logic i_sys_rst;
    logic i_release6;
    dmr_pkg::dmr_issue_t issue;
    dmr_pkg::dmr_rd_req_t rd_req;
    dmr_pkg::dmr_rot_res_t rot;
    dmr_pkg::dmr_rd_res_t rd_res;
    logic rsvd;
    logic shift_pass;
    logic mul_busy;
    int n_mismatch;
    int comparisons;

    dmr_unit i_dmr_unit (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_issue(issue), .i_release6(i_release6),
        .i_prod_rd(rd_req), .o_rot(rot), .o_prod_rd(rd_res), .o_rsvd_instr(rsvd),
        .o_shift_pass(shift_pass), .o_mul_busy(mul_busy));
    dmr_pipe_model i_dmr_pipe_model (.i_clk(i_clk), .i_rd_res(rd_res), .o_issue(issue), .o_rd_req(rd_req));

    initial begin
        i_clk = 1'h0;
        forever #4 i_clk = ~i_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [63:0] rot_ref(input logic [63:0] v, input int s);
        logic [63:0] r;
        r = v;
        for (int i = 0; i < s; i++) begin
            r = {r[0], r[63:1]};
        end
        return r;
    endfunction

    function automatic logic [31:0] rot_ins(input logic [5:0] fn, input logic sel, input logic [4:0] sa);
        return {dmr_pkg::OPC_SPECIAL, 4'h0, sel, 5'h04, 5'h05, sa, fn};
    endfunction

    function automatic logic [31:0] var_ins(input logic sel);
        return {dmr_pkg::OPC_SPECIAL, 5'h03, 5'h04, 5'h05, 4'h0, sel, dmr_pkg::FN_ROT_VAR};
    endfunction

    function automatic logic [31:0] mul_ins(input logic [5:0] fn, input logic [9:0] mid);
        return {dmr_pkg::OPC_SPECIAL, 5'h03, 5'h04, mid, fn};
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_rotate();
        logic [63:0] v;
        v = 64'h0123_4567_89AB_CDEF;
        for (int k = 0; k < 3; k++) begin
            i_dmr_pipe_model.issue(rot_ins(dmr_pkg::FN_ROT_IMM, 1'h1, 5'(k * 15 + k / 2)), 64'h0, v);
            check({rot.valid, rot.data}, {1'h1, rot_ref(v, k * 15 + k / 2)});
            i_dmr_pipe_model.issue(rot_ins(dmr_pkg::FN_ROT_IMM32, 1'h1, 5'(k * 15 + k / 2)), 64'h0, v);
            check({rot.valid, rot.data}, {1'h1, rot_ref(v, 32 + k * 15 + k / 2)});
            i_dmr_pipe_model.issue(var_ins(1'h1), {{58{1'h1}}, 6'(k * 31 + k / 2)}, v);
            check({rot.valid, rot.data}, {1'h1, rot_ref(v, k * 31 + k / 2)});
        end
        i_dmr_pipe_model.idle();
        @(negedge i_clk);
        check({rot.valid, shift_pass}, 2'h0);
        $display("test_rotate done");
    endtask

    task automatic test_shift_pass();
        logic [31:0] ins [3];
        ins[0] = rot_ins(dmr_pkg::FN_ROT_IMM, 1'h0, 5'h05);
        ins[1] = rot_ins(dmr_pkg::FN_ROT_IMM32, 1'h0, 5'h05);
        ins[2] = var_ins(1'h0);
        foreach (ins[k]) begin
            i_dmr_pipe_model.issue(ins[k], 64'h5, 64'hFFFF_0000_FFFF_0000);
            check({shift_pass, rot.valid}, 2'h2);
        end
        i_dmr_pipe_model.issue(rot_ins(dmr_pkg::FN_ROT_IMM, 1'h1, 5'h05) | 32'h0040_0000, 64'h5, 64'h1);
        check({shift_pass, rot.valid}, 2'h0);
        i_dmr_pipe_model.idle();
        @(negedge i_clk);
        $display("test_shift_pass done");
    endtask

    task automatic test_mul(input logic sgn, input logic [63:0] a, input logic [63:0] b);
        logic [127:0] exp;
        logic [63:0] lo;
        logic [63:0] hi;
        int st;
        exp = sgn ? {{64{a[63]}}, a} * {{64{b[63]}}, b} : {64'h0, a} * {64'h0, b};
        i_dmr_pipe_model.issue(mul_ins(sgn ? dmr_pkg::FN_MUL_SIGNED : dmr_pkg::FN_MUL_UNSIGNED, 10'h000), a, b);
        i_dmr_pipe_model.idle();
        check({mul_busy, rsvd}, 2'h2);
        i_dmr_pipe_model.read(1'h0, lo, st);
        check(st, dmr_pkg::MUL_LATENCY);
        check(mul_busy, 1'h0);
        i_dmr_pipe_model.read(1'h1, hi, st);
        check({hi, lo}, exp);
        $display("test_mul done");
    endtask

    task automatic test_refused(input logic [63:0] last_lo);
        logic [31:0] ins [3];
        logic [63:0] lo;
        int st;
        ins[0] = mul_ins(dmr_pkg::FN_MUL_SIGNED, 10'h000);
        ins[1] = mul_ins(dmr_pkg::FN_MUL_SIGNED, 10'h200);
        ins[2] = mul_ins(dmr_pkg::FN_MUL_UNSIGNED, 10'h001);
        foreach (ins[k]) begin
            i_release6 = (k == 0);
            i_dmr_pipe_model.issue(ins[k], 64'h2, 64'h3);
            check({rsvd, mul_busy}, {k == 0, 1'h0});
            i_dmr_pipe_model.idle();
            @(negedge i_clk);
        end
        i_dmr_pipe_model.read(1'h0, lo, st);
        check(lo, last_lo);
        check(st, 0);
        $display("test_refused done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        comparisons = 0;
        i_sys_rst = 1'h1;
        i_release6 = 1'h0;
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'h0;
        @(negedge i_clk);
        check({rot.valid, rd_res, rsvd, shift_pass, mul_busy}, '0);
        test_rotate();
        test_shift_pass();
        test_mul(1'h1, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF);
        test_mul(1'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF);
        test_mul(1'h1, 64'h8000_0000_0000_0000, 64'h0000_0000_0000_0003);
        test_refused(64'h8000_0000_0000_0000);
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge i_clk);
        n_mismatch++;
        finish_test();
    end
endmodule
